// ---- rtl/tmr3_pkg.sv ----
// package for the timer three control block: offsets, fields, types, constants
package tmr3_pkg;
    localparam logic [7:0] CTRL_ADDR      = 8'h91;
    localparam logic [3:0] CTRL_PAGE      = 4'h0;
    localparam logic [7:0] CTRL_RESET     = 8'h00;
    localparam int         BIT_HIGH_FLAG  = 7;
    localparam int         BIT_LOW_FLAG   = 6;
    localparam int         BIT_LOW_IRQEN  = 5;
    localparam int         BIT_CAPTURE    = 4;
    localparam int         BIT_SPLIT      = 3;
    localparam int         BIT_RUN        = 2;
    localparam int         BIT_CLKSEL_HI  = 1;
    localparam int         BIT_CLKSEL_LO  = 0;
    localparam logic [7:0] BYTE_MAX       = 8'hFF;
    localparam logic [15:0] COUNT_MAX     = 16'hFFFF;
    localparam logic [15:0] COUNT_RESET   = 16'h0000;

    // special function register bus request
    typedef struct packed {
        logic       wrEn;
        logic       rdEn;
        logic [3:0] page;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tmr3_sfr_req_t;

    // decoded control fields
    typedef struct packed {
        logic       lowIrqEnable;
        logic       captureEnable;
        logic       splitMode;
        logic       run;
        logic [1:0] altClockSelect;
    } tmr3_ctrl_t;
endpackage : tmr3_pkg

// ---- rtl/tmr3_counter.sv ----
// timer three 16-bit / split 8-bit auto-reload counter with capture
`timescale 1ns/1ps
module tmr3_counter (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                resetn,
    // control
    input  wire tmr3_pkg::tmr3_ctrl_t ctrl,
    input  wire logic                tickLow,
    input  wire logic                tickHigh,
    input  wire logic                captureTrig,
    // reload values written by software
    input  wire logic                reloadWr,
    input  wire logic [15:0]         reloadWdata,
    // state
    output logic [15:0]              count,
    output logic [15:0]              reload,
    output logic                     lowOverflow,
    output logic                     highOverflow
);
    logic        lowRun;
    logic        highRun;
    logic        lowWrap;
    logic        highWrap;
    logic        fullWrap;
    logic [15:0] next_count;

    // R8 run gating: low byte free in split mode
    assign lowRun   = ctrl.splitMode ? tickLow : (tickLow && ctrl.run);
    assign highRun  = ctrl.splitMode ? (tickHigh && ctrl.run) : 1'b0;
    assign lowWrap  = lowRun && (count[7:0] == tmr3_pkg::BYTE_MAX);
    // R7 16-bit mode wraps on all ones
    assign fullWrap = !ctrl.splitMode && lowRun && (count == tmr3_pkg::COUNT_MAX);
    assign highWrap = ctrl.splitMode ? (highRun && count[15:8] == tmr3_pkg::BYTE_MAX)
                                     : fullWrap;

    // R7 auto-reload selection per mode
    always_comb begin
        next_count = count;
        if (ctrl.splitMode) begin
            if (lowRun) begin
                next_count[7:0] = lowWrap ? reload[7:0] : count[7:0] + 8'h01;
            end
            if (highRun) begin
                next_count[15:8] = highWrap ? reload[15:8] : count[15:8] + 8'h01;
            end
        end else if (lowRun) begin
            next_count = fullWrap ? reload : count + 16'h0001;
        end
    end

    // counter and reload registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count  <= tmr3_pkg::COUNT_RESET;
            reload <= tmr3_pkg::COUNT_RESET;
        end else begin
            count <= next_count;
            // R9 capture copies count to reload
            if (ctrl.captureEnable && captureTrig) begin
                reload <= count;
            end else if (reloadWr) begin
                reload <= reloadWdata;
            end
        end
    end

    assign lowOverflow  = lowWrap;
    assign highOverflow = highWrap;
endmodule : tmr3_counter

// ---- rtl/tmr3_control.sv ----
// timer three control register, overflow flags and interrupt request
//
// Overview of operation
// R1: control register at 0x91 page 0, reset zero
// R2: high byte wrap sets high flag
// R3: 16-bit mode full wrap sets high flag
// R4: enabled timer interrupt requests on high flag
// R5: flag cleared only by software writing zero
// R6: overflow wins over simultaneous software clear
// R7: split bit picks 16-bit or two 8-bit
// R8: run gates whole timer, split only high
// R9: capture copies count, sets high flag
// R10: low overflow also interrupts when both enabled
`timescale 1ns/1ps
module tmr3_control (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   resetn,
    // special function register bus
    input  wire tmr3_pkg::tmr3_sfr_req_t sfrReq,
    output logic [7:0]                  sfrRdata,
    output logic                        sfrHit,
    // reload register access
    input  wire logic                   reloadWr,
    input  wire logic [15:0]            reloadWdata,
    // timing sources, same clock domain
    input  wire logic                   tickLow,
    input  wire logic                   tickHigh,
    // capture trigger from pin domain
    input  wire logic                   captureTrigAsync,
    // interrupt
    input  wire logic                   timerIrqEnable,
    output logic                        irqRequest,
    // timer state
    output logic [15:0]                 count,
    output logic [15:0]                 reload,
    output logic [1:0]                  altClockSelect
);
    logic                 highFlag;
    logic                 lowFlag;
    logic [5:0]           ctrlBits;
    logic                 capSync1;
    logic                 capSync2;
    logic                 capPrev;
    logic                 captureTrig;
    logic                 lowOverflow;
    logic                 highOverflow;
    logic                 regSel;
    logic                 regWrite;
    logic                 highSet;
    logic                 next_highFlag;
    logic                 next_lowFlag;
    tmr3_pkg::tmr3_ctrl_t ctrl;

    // R1 address and page decode
    assign regSel   = (sfrReq.addr == tmr3_pkg::CTRL_ADDR) && (sfrReq.page == tmr3_pkg::CTRL_PAGE);
    assign regWrite = regSel && sfrReq.wrEn;
    assign sfrHit   = regSel && (sfrReq.rdEn || sfrReq.wrEn);

    // field view of the control bits
    assign ctrl = ctrlBits;
    assign altClockSelect = ctrl.altClockSelect;

    // two-flop synchroniser then rising-edge detect on the trigger
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            capSync1 <= 1'b0;
            capSync2 <= 1'b0;
            capPrev  <= 1'b0;
        end else begin
            capSync1 <= captureTrigAsync;
            capSync2 <= capSync1;
            capPrev  <= capSync2;
        end
    end
    assign captureTrig = capSync2 && !capPrev;

    tmr3_counter u_counter (
        .clk          (clk),
        .resetn       (resetn),
        .ctrl         (ctrl),
        .tickLow      (tickLow),
        .tickHigh     (tickHigh),
        .captureTrig  (captureTrig),
        .reloadWr     (reloadWr),
        .reloadWdata  (reloadWdata),
        .count        (count),
        .reload       (reload),
        .lowOverflow  (lowOverflow),
        .highOverflow (highOverflow)
    );

    // R2 R3 R9 hardware set sources
    assign highSet = highOverflow || (ctrl.captureEnable && captureTrig);

    // R5 R6 software write, hardware set wins
    assign next_highFlag = highSet ? 1'b1
                         : (regWrite ? sfrReq.wdata[tmr3_pkg::BIT_HIGH_FLAG] : highFlag);
    assign next_lowFlag  = lowOverflow ? 1'b1
                         : (regWrite ? sfrReq.wdata[tmr3_pkg::BIT_LOW_FLAG] : lowFlag);

    // R1 control register storage, reset zero
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            highFlag <= tmr3_pkg::CTRL_RESET[tmr3_pkg::BIT_HIGH_FLAG];
            lowFlag  <= tmr3_pkg::CTRL_RESET[tmr3_pkg::BIT_LOW_FLAG];
            ctrlBits <= tmr3_pkg::CTRL_RESET[5:0];
        end else begin
            highFlag <= next_highFlag;
            lowFlag  <= next_lowFlag;
            if (regWrite) begin
                ctrlBits <= sfrReq.wdata[5:0];
            end
        end
    end

    // read data registered
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sfrRdata <= tmr3_pkg::CTRL_RESET;
        end else begin
            sfrRdata <= {highFlag, lowFlag, ctrlBits};
        end
    end

    // R4 R10 level request, flag never cleared here
    assign irqRequest = timerIrqEnable && (highFlag || (ctrl.lowIrqEnable && lowFlag));
endmodule : tmr3_control

// ---- test/tmr3_control_properties.sv ----
// concurrent checks on the timer three control block ports
`timescale 1ns/1ps
module tmr3_control_properties (
    // clock and reset
    input wire logic                    clk,
    input wire logic                    resetn,
    // register bus
    input wire tmr3_pkg::tmr3_sfr_req_t sfrReq,
    input wire logic [7:0]              sfrRdata,
    input wire logic                    sfrHit,
    // timer inputs and state
    input wire logic                    tickLow,
    input wire logic                    tickHigh,
    input wire logic                    captureTrigAsync,
    input wire logic                    timerIrqEnable,
    input wire logic                    irqRequest,
    input wire logic [15:0]             count
);
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!resetn);
    // software write of zero to the high flag
    wire flagClear = sfrHit && sfrReq.wrEn && !sfrReq.wdata[7];
    // accepted register write followed by a quiet cycle
    sequence ctrl_write;
        sfrHit && sfrReq.wrEn ##1 !sfrReq.wrEn;
    endsequence
    hit_decode_a: assert property (
        sfrHit == ((sfrReq.wrEn || sfrReq.rdEn) && sfrReq.page == 4'h0 && sfrReq.addr == 8'h91))
        else $error("decode wrong");
    write_seen_a: assert property (
        ctrl_write |=> sfrRdata[5:0] == $past(sfrReq.wdata[5:0], 2)) else $error("write lost");
    flag_hold_a: assert property (
        $fell(sfrRdata[7]) |-> $past(flagClear, 2)) else $error("flag dropped");
    irq_match_a: assert property (
        $past(irqRequest) == ($past(timerIrqEnable) && (sfrRdata[7] || sfrRdata[6] && sfrRdata[5])))
        else $error("irq wrong");
    wrap_full_a: assert property (
        count == 16'hFFFF && tickLow && sfrRdata[3:2] == 2'b01 |-> ##[1:3] sfrRdata[7])
        else $error("no full wrap flag");
    wrap_high_a: assert property (
        count[15:8] == 8'hFF && tickHigh && sfrRdata[3:2] == 2'b11 |-> ##[1:3] sfrRdata[7])
        else $error("no high wrap flag");
    wrap_low_a: assert property (
        count[7:0] == 8'hFF && tickLow && (sfrRdata[3] || sfrRdata[2])
        |-> ##[1:3] sfrRdata[6]) else $error("no low flag");
    capture_set_a: assert property (
        $rose(captureTrigAsync) && sfrRdata[4] |-> ##[2:6] sfrRdata[7])
        else $error("no capture flag");
endmodule : tmr3_control_properties

// ---- test/tmr3_cpu_model.sv ----
// processor side bus master that issues control register writes
`timescale 1ns/1ps
module tmr3_cpu_model (
    // clock
    input  wire logic              clk,
    // bus request
    output tmr3_pkg::tmr3_sfr_req_t sfrReq
);
    initial sfrReq = '0;
    // one-cycle strobe; released lines show inverted values
    task automatic writeReg(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk);
        sfrReq = '{1'b1, 1'b0, 4'h0, addr, data};
        @(negedge clk);
        sfrReq = '{1'b0, 1'b0, 4'hF, ~addr, ~data};
    endtask : writeReg
endmodule : tmr3_cpu_model

// ---- test/tmr3_control_test.sv ----
// self-checking bench for the timer three control block
`timescale 1ns/1ps
module tmr3_control_test;
    logic clk, resetn, reloadWr, tickLow, tickHigh, captureTrigAsync, timerIrqEnable, sfrHit;
    logic [15:0] reloadWdata, count, reload;
    logic [7:0] sfrRdata;
    logic [1:0] altClockSelect;
    logic irqRequest;
    tmr3_pkg::tmr3_sfr_req_t sfrReq;
    int numErrors = 0;
    int comparisons = 0;
    tmr3_cpu_model u_tmr3_cpu_model (.clk(clk), .sfrReq(sfrReq));
    tmr3_control u_tmr3_control (.clk(clk), .resetn(resetn), .sfrReq(sfrReq),
        .sfrRdata(sfrRdata), .sfrHit(sfrHit), .reloadWr(reloadWr), .reloadWdata(reloadWdata),
        .tickLow(tickLow), .tickHigh(tickHigh), .captureTrigAsync(captureTrigAsync),
        .timerIrqEnable(timerIrqEnable), .irqRequest(irqRequest), .count(count),
        .reload(reload), .altClockSelect(altClockSelect));
    // free-running clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // verdict and end of run
    task automatic wrapUp();
        if (numErrors == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : wrapUp
    // compare one value
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            numErrors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // write then look at the register image two cycles on
    task automatic wrRd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
        u_tmr3_cpu_model.writeReg(a, d);
        repeat (2) @(negedge clk);
        check(sfrRdata, e);
    endtask : wrRd
    // bounded wait for a flag bit of the image
    task automatic waitFlag(input int b, input int limit);
        int n;
        n = 0;
        while (sfrRdata[b] !== 1'b1 && n < limit) begin
            @(negedge clk);
            n++;
        end
        if (n >= limit) begin
            numErrors++;
            $display("mismatch at %0t: timeout", $time);
            wrapUp();
        end
    endtask : waitFlag
    // main sequence
    initial begin
        {resetn, reloadWr, tickLow, tickHigh, captureTrigAsync, timerIrqEnable} = '0;
        reloadWdata = 16'hFFF0;
        repeat (4) @(negedge clk);
        resetn = 1'b1;
        @(negedge clk);
        check(sfrRdata, 16'h0000);
        wrRd(8'h92, 8'h3F, 8'h00);
        wrRd(8'h91, 8'h3B, 8'h3B);
        check(altClockSelect, 16'h0003);
        wrRd(8'h91, 8'h00, 8'h00);
        timerIrqEnable = 1'b1;
        reloadWr = 1'b1;
        @(negedge clk);
        reloadWr = 1'b0;
        u_tmr3_cpu_model.writeReg(8'h91, 8'h04);
        tickLow = 1'b1;
        waitFlag(7, 70000);
        tickLow = 1'b0;
        repeat (20) @(negedge clk);
        check(sfrRdata, 16'h00C4);
        check(irqRequest, 16'h0001);
        wrRd(8'h91, 8'h04, 8'h04);
        check(irqRequest, 16'h0000);
        u_tmr3_cpu_model.writeReg(8'h91, 8'h28);
        tickLow = 1'b1;
        waitFlag(6, 300);
        tickLow = 1'b0;
        tickHigh = 1'b1;
        repeat (300) @(negedge clk);
        tickHigh = 1'b0;
        check(sfrRdata, 16'h0068);
        check(irqRequest, 16'h0001);
        u_tmr3_cpu_model.writeReg(8'h91, 8'h0C);
        tickHigh = 1'b1;
        waitFlag(7, 300);
        tickHigh = 1'b0;
        wrRd(8'h91, 8'h10, 8'h10);
        captureTrigAsync = 1'b1;
        repeat (8) @(negedge clk);
        check(reload, count);
        check(sfrRdata, 16'h0090);
        wrapUp();
    end
endmodule : tmr3_control_test
bind tmr3_control tmr3_control_properties u_tmr3_control_properties (.clk(clk),
    .resetn(resetn), .sfrReq(sfrReq), .sfrRdata(sfrRdata), .sfrHit(sfrHit), .tickLow(tickLow),
    .tickHigh(tickHigh), .captureTrigAsync(captureTrigAsync), .timerIrqEnable(timerIrqEnable),
    .irqRequest(irqRequest), .count(count));
